// >>> verilog/wds_defines.svh
// Offsets, field positions, reset values and counts of the watchdog setup/state block
`ifndef WDS_DEFINES_SVH
`define WDS_DEFINES_SVH

`define WDS_ADDR_SETUP 8'h00
`define WDS_ADDR_STATE 8'h01
`define WDS_ADDR_IRQ_STAT 8'h02
`define WDS_ADDR_IRQ_EN 8'h03
`define WDS_ADDR_IRQ_CLR 8'h04

`define WDS_WIN_HI 7
`define WDS_WIN_LO 4
`define WDS_PER_HI 3
`define WDS_PER_LO 0
`define WDS_FREEZE_BIT 7
`define WDS_PEND_BIT 0

`define WDS_STATE_RESET 8'h00
`define WDS_SETUP_PRE 8'h00
`define WDS_CODE_MAX 4'h0B
`define WDS_BASE_TICKS 14'h0008
`define WDS_SYNC_TICKS 2'h2
`define WDS_RST_HOLD 16

`define WDS_IRQ_TIMEOUT 0
`define WDS_IRQ_EARLY 1
`define WDS_IRQ_SYNC 2
`define WDS_IRQ_W 3

`endif

// >>> verilog/wds_pkg.sv
// Types of the watchdog setup/state block
package wds_pkg;

    typedef enum logic [1:0] {
        WDS_OFF,
        WDS_FIRST,
        WDS_CLOSED,
        WDS_OPEN
    } wds_phase_type;

    typedef struct packed {
        logic [3:0] closed_period_select;
        logic [3:0] timeout_select;
    } wds_setup_type;

    typedef struct packed {
        logic init_done;
        logic tick_q;
        wds_setup_type setup;
        wds_setup_type active;
        logic config_freeze;
        logic xfer_pending;
        logic [1:0] sync_cnt;
        logic kick_pend;
        wds_phase_type phase;
        logic [13:0] count;
        logic sys_reset;
        logic [4:0] hold_cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic [7:0] rdata;
    } wds_state_type;

endpackage : wds_pkg

// >>> verilog/wds_top.sv
// Watchdog setup and state registers with normal and window timeout logic
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "wds_defines.svh"

module wds_top import wds_pkg::*; #(
    parameter int CNT_W = 14,
    parameter int RST_HOLD = `WDS_RST_HOLD
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Device side
    input wire logic [7:0] fuse_watchdog_setup,
    input wire logic change_protect_gate,
    input wire logic debug_mode,
    input wire logic kick_instruction,
    input wire logic slow_tick,
    // Results
    output logic sys_reset,
    output logic irq
);

    generate
        if (CNT_W < 14) begin : g_bad_width
            $error("CNT_W must hold 8K ticks");
        end
        if (RST_HOLD < 1 || RST_HOLD > 31) begin : g_bad_hold
            $error("RST_HOLD must be 1 to 31");
        end
    endgenerate

    localparam logic [4:0] HOLD_LAST = 5'(RST_HOLD - 1);

    logic [1:0] rst_sync_ff;
    logic rst_n_int;
    wds_state_type state_ff;
    wds_state_type nxt_state;

    // Codes above the top one are reserved; they are served as the longest length
    function automatic logic [13:0] wds_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `WDS_CODE_MAX) ? `WDS_CODE_MAX : code;
        wds_len = `WDS_BASE_TICKS << (c - 4'h1);
    endfunction : wds_len

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n_int = rst_sync_ff[1];

    logic tick_edge;
    logic wr_setup;
    logic wr_state;
    logic wr_clr;
    logic [2:0] ev;
    logic [13:0] open_len;
    logic [13:0] closed_len;
    logic win_on;
    logic fire;

    always_comb begin
        nxt_state = state_ff;
        ev = 3'h0;
        fire = 1'b0;
        tick_edge = slow_tick & ~state_ff.tick_q;
        nxt_state.tick_q = slow_tick;
        wr_setup = reg_wr && (reg_addr == `WDS_ADDR_SETUP);
        wr_state = reg_wr && (reg_addr == `WDS_ADDR_STATE);
        wr_clr = reg_wr && (reg_addr == `WDS_ADDR_IRQ_CLR);
        open_len = wds_len(state_ff.active.timeout_select);
        closed_len = wds_len(state_ff.active.closed_period_select);
        win_on = (state_ff.active.closed_period_select != 4'h0);

        if (!state_ff.init_done) begin
            // Fuse is caught by a clocked load after reset release, not by the reset itself
            nxt_state.init_done = 1'b1;
            nxt_state.setup = fuse_watchdog_setup;
            nxt_state.active = fuse_watchdog_setup;
            nxt_state.config_freeze =
                (fuse_watchdog_setup[`WDS_PER_HI:`WDS_PER_LO] != 4'h0);
            nxt_state.phase = WDS_FIRST;
            nxt_state.count = 14'h0000;
        end else begin
            // Writes during a crossing are not served; the pending flag tells software to wait
            if (wr_setup && change_protect_gate && !state_ff.config_freeze
                    && !state_ff.xfer_pending) begin
                nxt_state.setup = reg_wdata;
                nxt_state.xfer_pending = 1'b1;
                nxt_state.sync_cnt = 2'h0;
            end
            if (wr_state && change_protect_gate) begin
                if (reg_wdata[`WDS_FREEZE_BIT]) begin
                    nxt_state.config_freeze = 1'b1;
                end else if (debug_mode) begin
                    nxt_state.config_freeze = 1'b0;
                end
            end
            if (kick_instruction) begin
                nxt_state.kick_pend = 1'b1;
            end

            if (state_ff.xfer_pending && tick_edge) begin
                if (state_ff.sync_cnt == `WDS_SYNC_TICKS - 2'h1) begin
                    nxt_state.xfer_pending = 1'b0;
                    nxt_state.active = state_ff.setup;
                    nxt_state.phase = WDS_FIRST;
                    nxt_state.count = 14'h0000;
                    ev[`WDS_IRQ_SYNC] = 1'b1;
                end else begin
                    nxt_state.sync_cnt = state_ff.sync_cnt + 2'h1;
                end
            end else if (debug_mode) begin
                // A halted core keeps the counter at zero and restarts with a plain interval
                nxt_state.count = 14'h0000;
                nxt_state.phase = WDS_FIRST;
                nxt_state.kick_pend = 1'b0;
            end else if (tick_edge) begin
                nxt_state.kick_pend = 1'b0;
                unique case (state_ff.phase)
                    WDS_OFF: begin
                        nxt_state.count = 14'h0000;
                        if (state_ff.active.timeout_select != 4'h0) begin
                            nxt_state.phase = WDS_FIRST;
                        end
                    end
                    WDS_FIRST: begin
                        if (state_ff.kick_pend) begin
                            nxt_state.count = 14'h0000;
                            nxt_state.phase = win_on ? WDS_CLOSED : WDS_FIRST;
                        end else if (state_ff.count == open_len - 14'h0001) begin
                            fire = 1'b1;
                            ev[`WDS_IRQ_TIMEOUT] = 1'b1;
                        end else begin
                            nxt_state.count = state_ff.count + 14'h0001;
                        end
                    end
                    WDS_CLOSED: begin
                        if (state_ff.kick_pend) begin
                            fire = 1'b1;
                            ev[`WDS_IRQ_EARLY] = 1'b1;
                        end else if (state_ff.count == closed_len - 14'h0001) begin
                            nxt_state.count = 14'h0000;
                            nxt_state.phase = WDS_OPEN;
                        end else begin
                            nxt_state.count = state_ff.count + 14'h0001;
                        end
                    end
                    WDS_OPEN: begin
                        if (state_ff.kick_pend) begin
                            nxt_state.count = 14'h0000;
                            nxt_state.phase = WDS_CLOSED;
                        end else if (state_ff.count == open_len - 14'h0001) begin
                            fire = 1'b1;
                            ev[`WDS_IRQ_TIMEOUT] = 1'b1;
                        end else begin
                            nxt_state.count = state_ff.count + 14'h0001;
                        end
                    end
                endcase
                if (state_ff.active.timeout_select == 4'h0) begin
                    nxt_state.phase = WDS_OFF;
                    nxt_state.count = 14'h0000;
                    fire = 1'b0;
                    ev[`WDS_IRQ_TIMEOUT] = 1'b0;
                    ev[`WDS_IRQ_EARLY] = 1'b0;
                end
                if (fire) begin
                    nxt_state.phase = WDS_FIRST;
                    nxt_state.count = 14'h0000;
                end
            end
        end

        // System reset stands for a fixed number of clocks
        if (fire) begin
            nxt_state.sys_reset = 1'b1;
            nxt_state.hold_cnt = 5'h00;
        end else if (state_ff.sys_reset) begin
            if (state_ff.hold_cnt == HOLD_LAST) begin
                nxt_state.sys_reset = 1'b0;
            end else begin
                nxt_state.hold_cnt = state_ff.hold_cnt + 5'h01;
            end
        end

        // Set wins over clear so no event is lost
        if (wr_clr) begin
            nxt_state.irq_stat = state_ff.irq_stat & ~reg_wdata[`WDS_IRQ_W-1:0];
        end
        nxt_state.irq_stat = nxt_state.irq_stat | ev;
        if (reg_wr && (reg_addr == `WDS_ADDR_IRQ_EN)) begin
            nxt_state.irq_en = reg_wdata[`WDS_IRQ_W-1:0];
        end

        nxt_state.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `WDS_ADDR_SETUP: nxt_state.rdata = state_ff.setup;
                `WDS_ADDR_STATE: begin
                    nxt_state.rdata[`WDS_FREEZE_BIT] = state_ff.config_freeze;
                    nxt_state.rdata[`WDS_PEND_BIT] = state_ff.xfer_pending;
                end
                `WDS_ADDR_IRQ_STAT: nxt_state.rdata = {5'h00, state_ff.irq_stat};
                `WDS_ADDR_IRQ_EN: nxt_state.rdata = {5'h00, state_ff.irq_en};
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_ff <= '{
                init_done: 1'b0,
                tick_q: 1'b0,
                setup: `WDS_SETUP_PRE,
                active: `WDS_SETUP_PRE,
                config_freeze: 1'b0,
                xfer_pending: 1'b0,
                sync_cnt: 2'h0,
                kick_pend: 1'b0,
                phase: WDS_OFF,
                count: 14'h0000,
                sys_reset: 1'b0,
                hold_cnt: 5'h00,
                irq_stat: 3'h0,
                irq_en: 3'h0,
                rdata: `WDS_STATE_RESET
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata = state_ff.rdata;
    assign sys_reset = state_ff.sys_reset;
    assign irq = |(state_ff.irq_stat & state_ff.irq_en);

endmodule : wds_top

// >>> verification/wds_assertions.sv
// Port checker for the watchdog setup block
`timescale 1ns/1ps
module wds_checker #(
    parameter int CNT_W = 14,
    parameter int RST_HOLD = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Device side
    input wire logic debug_mode,
    input wire logic slow_tick,
    // Results
    input wire logic sys_reset,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    int hcnt_ff;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hcnt_ff <= 0;
        end else begin
            hcnt_ff <= sys_reset ? hcnt_ff + 1 : 0;
        end
    end
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    a_state_fmt: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[6:1] == 6'h00)
        else $error("state spare bits set");
    a_unmapped: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_hold_min: assert property ($rose(sys_reset) |-> sys_reset [*8])
        else $error("reset pulse short");
    a_hold_len: assert property ($fell(sys_reset) |-> hcnt_ff == RST_HOLD)
        else $error("reset pulse length wrong");
    a_tick_cause: assert property ($rose(sys_reset) |-> $past(slow_tick))
        else $error("reset without tick");
    a_reset_gap: assert property ($fell(sys_reset) |-> !sys_reset [*4])
        else $error("reset retriggered at once");
    a_debug_quiet: assert property (debug_mode [*8] |-> !$rose(sys_reset))
        else $error("reset while halted");
    c_reset: cover property ($rose(sys_reset));
    c_irq: cover property ($rose(irq));
    c_state_rd: cover property (reg_rd && reg_addr == 8'h01);
endmodule : wds_checker

bind wds_top wds_checker #(.CNT_W(CNT_W), .RST_HOLD(RST_HOLD)) wds_checker_inst (.mclk,
    .rstn, .reg_addr, .reg_rd, .reg_rdata, .debug_mode, .slow_tick, .sys_reset, .irq);

// >>> verification/wds_partner.sv
// Far-side model: tick source and refresh issuer
`timescale 1ns/1ps
module wds_partner #(
    parameter int TICK_CYC = 20
) (
    // Clock
    input wire logic mclk,
    // Bench request
    input wire logic kick_req,
    // Toward the block
    output logic slow_tick,
    output logic kick_instruction
);
    // Scaled tick keeps runs short; high four cycles per period
    int cnt_ff = 0;
    initial slow_tick = 1'b0;
    initial kick_instruction = 1'b0;
    always @(posedge mclk) begin
        cnt_ff <= (cnt_ff == TICK_CYC - 1) ? 0 : cnt_ff + 1;
        slow_tick <= cnt_ff < 4;
        kick_instruction <= kick_req;
    end
endmodule : wds_partner

// >>> verification/wds_top_bench.sv
// Self-checking bench for the watchdog setup block
`timescale 1ns/1ps
module wds_top_bench;
    logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, gate = 0, dbg = 0, kick_req = 0, tq = 0;
    logic [7:0] addr = 0, wdata = 0, fuse = 0, rdata, d;
    logic slow_tick, kick, sys_reset, irq;
    int err_count = 0, n_tests = 0, cyc = 0, ticks = 0, t0, i;
    // Rows: setup value, ticks until the timeout reset
    int rows [4][2] = '{'{1, 8}, '{2, 16}, '{8'h13, 32}, '{8'h21, 8}};
    wds_top #(.RST_HOLD(16)) wds_top_inst (.mclk(mclk), .rstn(rstn), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .fuse_watchdog_setup(fuse), .change_protect_gate(gate), .debug_mode(dbg),
        .kick_instruction(kick), .slow_tick(slow_tick), .sys_reset(sys_reset), .irq(irq));
    wds_partner wds_partner_inst (.mclk(mclk), .kick_req(kick_req), .slow_tick(slow_tick),
        .kick_instruction(kick));
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        tq <= slow_tick;
        if (slow_tick && !tq) ticks <= ticks + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task finish_test;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk8
    task chkn(input int g, input int e);
        n_tests++;
        if (g != e) begin
            err_count++;
            $display("[ERR] %0t count %0d exp %0d", $time, g, e);
        end
    endtask : chkn
    task wr(input logic [7:0] a, input logic [7:0] w, input logic g);
        @(posedge mclk);
        addr <= a;
        wdata <= w;
        gate <= g;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        gate <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task idle;
        for (int k = 0; k < 100; k++) begin
            rd(8'h01);
            if (d[0] === 1'b0) break;
        end
        chk8(d & 8'h01, 8'h00);
    endtask : idle
    task wait_rst(input int lim);
        // Look after the edge has settled on every wait; the first check runs at once, in the time step of the caller
        for (int k = 0; k < lim && sys_reset !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
    endtask : wait_rst
    task kick_once;
        @(posedge mclk) kick_req <= 1'b1;
        @(posedge mclk) kick_req <= 1'b0;
    endtask : kick_once
    task do_reset(input logic [7:0] f);
        rstn <= 1'b0;
        fuse <= f;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : do_reset
    initial begin
        do_reset(8'h00);
        rd(8'h00); chk8(d, 8'h00);
        rd(8'h01); chk8(d, 8'h00);
        rd(8'h09); chk8(d, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(8'h00, 8'(rows[i][0]), 1'b1);
            idle();
            t0 = ticks;
            wait_rst(rows[i][1] * 20 + 60);
            chk8({7'b0, sys_reset}, 8'h01);
            chkn(ticks - t0, rows[i][1]);
            wr(8'h00, 8'h00, 1'b1);
            idle();
        end
        rd(8'h02); chk8(d & 8'h04, 8'h04);
        // Window: first interval plain, a kick in the open part, then one in the closed part
        wr(8'h04, 8'h07, 1'b1);
        wr(8'h00, 8'h11, 1'b1);
        idle();
        repeat (40) @(posedge mclk);
        kick_once();
        repeat (40) @(posedge mclk);
        chk8({7'b0, sys_reset}, 8'h00);
        repeat (200) @(posedge mclk);
        kick_once();
        repeat (40) @(posedge mclk);
        chk8({7'b0, sys_reset}, 8'h00);
        kick_once();
        wait_rst(60);
        chk8({7'b0, sys_reset}, 8'h01);
        rd(8'h02); chk8(d & 8'h02, 8'h02);
        wr(8'h03, 8'h02, 1'b1);
        #1 chk8({7'b0, irq}, 8'h01);
        wr(8'h04, 8'h02, 1'b1);
        #1 chk8({7'b0, irq}, 8'h00);
        wr(8'h00, 8'h00, 1'b1);
        idle();
        wr(8'h00, 8'h05, 1'b0); rd(8'h00); chk8(d, 8'h00);
        wr(8'h00, 8'h01, 1'b1); rd(8'h01); chk8(d, 8'h01);
        idle();
        wr(8'h01, 8'h81, 1'b0); rd(8'h01); chk8(d, 8'h00);
        wr(8'h01, 8'h81, 1'b1); rd(8'h01); chk8(d, 8'h80);
        wr(8'h00, 8'h03, 1'b1); rd(8'h00); chk8(d, 8'h01);
        wr(8'h01, 8'h00, 1'b1); rd(8'h01); chk8(d, 8'h80);
        @(posedge mclk) dbg <= 1'b1;
        wr(8'h01, 8'h00, 1'b1);
        repeat (10) @(posedge mclk);
        rd(8'h01); chk8(d, 8'h00);
        @(posedge mclk) dbg <= 1'b0;
        do_reset(8'h12);
        rd(8'h00); chk8(d, 8'h12);
        rd(8'h01); chk8(d, 8'h80);
        do_reset(8'h10);
        rd(8'h01); chk8(d, 8'h00);
        finish_test();
    end
endmodule : wds_top_bench
